/* dv/hdp_mem_model.sv */
// behavioural dram answering the memory port
`timescale 1ns/1ps
module hdp_mem_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [17:0] mem_addr_i,
    input wire logic [15:0] mem_wdata_i,
    input wire logic [3:0] lat_i,
    output logic mem_ack_o,
    output logic [15:0] mem_rdata_o
);
    logic [15:0] mem [32];
    logic [3:0] wait_reg;
    // data toggles outside an acknowledge so a stale word never looks valid
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_reg <= 4'h0;
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 16'h5A5A;
        end else begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            if (mem_req_i && !mem_ack_o && wait_reg != lat_i) begin
                wait_reg <= wait_reg + 4'h1;
            end else if (mem_req_i && !mem_ack_o) begin
                wait_reg <= 4'h0;
                mem_ack_o <= 1'b1;
                if (mem_we_i) mem[mem_addr_i[4:0]] <= mem_wdata_i;
                else mem_rdata_o <= mem[mem_addr_i[4:0]];
            end
        end
    end
endmodule

/* dv/hdp_top_bench.sv */
// self-checking bench for the host dma and frame buffer port
`timescale 1ns/1ps
module hdp_top_bench;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic reg_byte_i = 1'b0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic [15:0] reg_rdata_o, mem_wdata_o, mem_rdata_i, tx_data_o, rd;
    logic [15:0] rx_data_i = 16'h0000;
    logic reg_rvalid_o, mem_req_o, mem_we_o, mem_ack_i, rx_ready_o, tx_valid_o;
    logic tx_frame_ok_o, tx_frame_drop_o;
    logic [17:0] mem_addr_o;
    logic rx_frame_i = 1'b0;
    logic rx_valid_i = 1'b0;
    logic rx_last_i = 1'b0;
    logic tx_ready_i = 1'b0;
    logic tx_space_i = 1'b1;
    logic [3:0] lat = 4'h0;
    logic [1:0] sc = 2'h0;
    logic [7:0] lo;
    logic [7:0] wb [6] = '{8'hB2, 8'hA1, 8'hD4, 8'hC3, 8'hE5, 8'h00};
    logic [25:0] rows [12];
    logic [15:0] txq [$];
    int fail_count = 0;
    int checked = 0;
    int acks = 0;
    int oks = 0;
    int drops = 0;

    hdp_top hdp_top_inst (.clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_byte_i,
        .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .mem_req_o, .mem_we_o, .mem_addr_o,
        .mem_wdata_o, .mem_ack_i, .mem_rdata_i, .rx_frame_i, .rx_valid_i, .rx_data_i,
        .rx_last_i, .rx_ready_o, .tx_valid_o, .tx_data_o, .tx_ready_i, .tx_space_i,
        .tx_frame_ok_o, .tx_frame_drop_o);
    hdp_mem_model hdp_mem_model_inst (.clk_i, .rst_n_i, .mem_req_i(mem_req_o),
        .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
        .lat_i(lat), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

    initial forever #50 clk_i = ~clk_i;
    // receiver stalls one cycle in four
    always @(negedge clk_i) begin
        sc <= sc + 2'h1;
        tx_ready_i <= (sc != 2'h0);
    end
    always @(posedge clk_i) begin
        if (mem_req_o && mem_ack_i) acks++;
        if (tx_valid_o && tx_ready_i) txq.push_back(tx_data_o);
        oks += int'(tx_frame_ok_o);
        drops += int'(tx_frame_drop_o);
    end
    ////////////////////////////////////////
    task automatic wrap_up();
        if (fail_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        rd = reg_rdata_o;
        cmp({15'h0000, reg_rvalid_o}, 16'h0001);
    endtask
    task automatic poll(input logic [7:0] a, input int b);
        int n = 0;
        rdr(a);
        while (rd[b] !== 1'b1 && n < 400) begin
            rdr(a);
            n++;
        end
        if (n >= 400) begin
            fail_count++;
            wrap_up();
        end
    endtask
    // flag alone set, then cleared by writing one
    // word mode here: byte mode would hide and never clear bits above seven
    task automatic wait_flag(input int b);
        logic m;
        m = reg_byte_i;
        reg_byte_i = 1'b0;
        poll(8'h40, b);
        cmp(rd, 16'h0001 << b);
        wr(8'h40, 16'h0001 << b);
        rdr(8'h40);
        cmp(rd, 16'h0000);
        reg_byte_i = m;
    endtask
    task automatic feed();
        int n;
        for (int i = 0; i < 6; i++) begin
            @(negedge clk_i);
            rx_valid_i = 1'b1;
            rx_data_i = 16'hB0A0 + 16'(i);
            rx_last_i = (i == 5);
            n = 0;
            while (rx_ready_o !== 1'b1 && n < 400) begin
                @(negedge clk_i);
                n++;
            end
            if (n >= 400) begin
                fail_count++;
                wrap_up();
            end
        end
        @(negedge clk_i);
        rx_valid_i = 1'b0;
        rx_last_i = 1'b0;
    endtask
    ////////////////////////////////////////
    initial begin
        rows = '{{2'b00, 8'h40, 16'h0000}, {2'b00, 8'h50, 16'h0000}, {2'b00, 8'h54, 16'h0000},
            {2'b11, 8'h50, 16'h0034}, {2'b11, 8'h51, 16'h0012}, {2'b11, 8'h52, 16'h00FF},
            {2'b00, 8'h50, 16'h1234}, {2'b00, 8'h52, 16'h0003}, {2'b01, 8'h54, 16'h0003},
            {2'b00, 8'h54, 16'h0003}, {2'b00, 8'h56, 16'h0000}, {2'b00, 8'h4E, 16'h0000}};
        repeat (5) @(negedge clk_i);
        rst_n_i = 1'b1;
        @(negedge clk_i);
        cmp({14'h0000, rx_ready_o, mem_req_o}, 16'h0002);
        foreach (rows[i]) begin
            reg_byte_i = rows[i][25];
            if (rows[i][24]) wr(rows[i][23:16], rows[i][15:0]);
            else begin
                rdr(rows[i][23:16]);
                cmp(rd, rows[i][15:0]);
            end
        end
        // dma write of five bytes, second start while busy
        reg_byte_i = 1'b0;
        wr(8'h50, 16'h0010);
        reg_byte_i = 1'b1;
        for (int i = 0; i < 5; i++) wr(8'h5E, {8'h00, wb[i]});
        lat = 4'h5;
        acks = 0;
        wr(8'h5A, 16'h0001);
        wr(8'h5A, 16'h0001);
        wait_flag(6);
        cmp(16'(acks), 16'h0003);
        cmp(hdp_mem_model_inst.mem[16], 16'hA1B2);
        cmp(hdp_mem_model_inst.mem[17], 16'hC3D4);
        cmp({8'h00, hdp_mem_model_inst.mem[18][7:0]}, 16'h00E5);
        // dma read back, whole last word in byte mode
        reg_byte_i = 1'b0;
        wr(8'h50, 16'h0010);
        reg_byte_i = 1'b1;
        lat = 4'h0;
        acks = 0;
        wr(8'h56, 16'h0001);
        wait_flag(6);
        cmp(16'(acks), 16'h0003);
        for (int i = 0; i < 6; i++) begin
            rdr(8'h5E);
            cmp({8'h00, rd[7:0]}, {8'h00, wb[i]});
        end
        // received frame: one full block and a partial one
        @(negedge clk_i);
        rx_frame_i = 1'b1;
        @(negedge clk_i);
        rx_frame_i = 1'b0;
        wait_flag(8);
        fork
            feed();
            for (int i = 0; i < 6; i++) begin
                if (i % 4 == 0) poll(8'h4E, 0);
                rdr(8'h48);
                lo = rd[7:0];
                rdr(8'h48);
                cmp({rd[7:0], lo}, 16'hB0A0 + 16'(i));
            end
        join
        rdr(8'h48);
        cmp(rd, 16'h0000);
        // two-block frame stored, then a frame refused for lack of space
        reg_byte_i = 1'b0;
        for (int i = 0; i < 7; i++) begin
            wr(8'h48, 16'hC000 + 16'(i));
            if (i == 3) begin
                wr(8'h4C, 16'h0001);
                wait_flag(10);
            end
            if (i == 5) begin
                wr(8'h4A, 16'h0001);
                wait_flag(10);
                tx_space_i = 1'b0;
            end
        end
        wr(8'h4A, 16'h0001);
        wait_flag(9);
        repeat (4) @(negedge clk_i);
        cmp({8'(oks), 8'(drops)}, 16'h0101);
        cmp(16'(txq.size()), 16'h0007);
        foreach (txq[i]) cmp(txq[i], 16'hC000 + 16'(i));
        wrap_up();
    end
endmodule

/* dv/hdp_top_props.sv */
// port-level assertions for the host dma and frame buffer port
`timescale 1ns/1ps
module hdp_top_props #(
    parameter int MAX_WORDS = hdp_pkg::DMA_MAX,
    parameter int BLK = hdp_pkg::BLK_WORDS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reg_rd_i,
    input wire logic reg_rvalid_o,
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic [17:0] mem_addr_o,
    input wire logic [15:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic rx_valid_i,
    input wire logic rx_last_i,
    input wire logic rx_ready_o,
    input wire logic tx_valid_o,
    input wire logic [15:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic tx_frame_ok_o,
    input wire logic tx_frame_drop_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////
    // words taken in the current receive block
    logic [3:0] blk_cnt_reg;
    logic [3:0] blk_cnt_next;
    assign blk_cnt_next = !rx_ready_o ? 4'h0 : blk_cnt_reg + {3'h0, rx_valid_i};
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) blk_cnt_reg <= 4'h0;
        else blk_cnt_reg <= blk_cnt_next;
    end
    ////////////////////////////////////////
    rd_answer_a: assert property (reg_rvalid_o == $past(reg_rd_i))
        else $error("read answer not one cycle after strobe");
    mem_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
        && $stable(mem_wdata_o) && $stable(mem_we_o))
        else $error("memory request changed before acknowledge");
    mem_gap_a: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
        else $error("memory request not dropped after acknowledge");
    addr_step_a: assert property (mem_req_o && mem_ack_i ##2 mem_req_o
        |-> mem_addr_o == $past(mem_addr_o, 2) + 18'h00001)
        else $error("memory address did not step by one");
    tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("transmit word lost during stall");
    ok_drop_a: assert property (!(tx_frame_ok_o && tx_frame_drop_o))
        else $error("frame both stored and dropped");
    end_pulse_a: assert property (tx_frame_ok_o || tx_frame_drop_o
        |=> !tx_frame_ok_o && !tx_frame_drop_o)
        else $error("frame result pulse longer than one cycle");
    rx_block_a: assert property (rx_valid_i && rx_ready_o
        && (rx_last_i || blk_cnt_reg == 4'(BLK - 1)) |=> !rx_ready_o)
        else $error("receive not stalled at block end");
    cover property (mem_req_o && mem_ack_i && mem_we_o);
    cover property (mem_req_o && mem_ack_i && !mem_we_o);
    cover property (tx_frame_ok_o);
    cover property (tx_frame_drop_o);
endmodule

bind hdp_top hdp_top_props #(.MAX_WORDS(MAX_WORDS), .BLK(BLK)) hdp_top_props_inst (
    .clk_i, .rst_n_i, .reg_rd_i, .reg_rvalid_o, .mem_req_o, .mem_we_o, .mem_addr_o,
    .mem_wdata_o, .mem_ack_i, .rx_valid_i, .rx_last_i, .rx_ready_o, .tx_valid_o,
    .tx_data_o, .tx_ready_i, .tx_frame_ok_o, .tx_frame_drop_o
);

/* verilog/hdp_buf2.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module hdp_buf2 #(
    parameter int WIDTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    if (WIDTH < 1) begin : g_chk
        $error("hdp_buf2: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] e1_reg;
    logic v1_reg;
    wire pop = out_valid_o & out_ready_i;
    wire push = in_valid_i & ~v1_reg;

    // ready comes from the second slot only, so it is a flop
    assign in_ready_o = ~v1_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_valid_o <= 1'b0;
            v1_reg <= 1'b0;
            out_data_o <= '0;
            e1_reg <= '0;
        end else if (pop) begin
            out_data_o <= v1_reg ? e1_reg : in_data_i;
            out_valid_o <= v1_reg | push;
            v1_reg <= v1_reg & push;
            if (push) begin
                e1_reg <= in_data_i;
            end
        end else if (push) begin
            if (!out_valid_o) begin
                out_data_o <= in_data_i;
                out_valid_o <= 1'b1;
            end else begin
                e1_reg <= in_data_i;
                v1_reg <= 1'b1;
            end
        end
    end
endmodule

/* verilog/hdp_pkg.sv */
// constants shared by the host dma and frame buffer port
package hdp_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_IRQ = 8'h40;
    localparam logic [7:0] OFS_FB = 8'h48;
    localparam logic [7:0] OFS_EOF = 8'h4A;
    localparam logic [7:0] OFS_BLK = 8'h4C;
    localparam logic [7:0] OFS_RDY = 8'h4E;
    localparam logic [7:0] OFS_ALO = 8'h50;
    localparam logic [7:0] OFS_AHI = 8'h52;
    localparam logic [7:0] OFS_LEN = 8'h54;
    localparam logic [7:0] OFS_DRD = 8'h56;
    localparam logic [7:0] OFS_DWR = 8'h5A;
    localparam logic [7:0] OFS_DQ = 8'h5E;

    // interrupt flag positions and the go bit
    localparam int IRQ_DMA = 6;
    localparam int IRQ_RXF = 8;
    localparam int IRQ_FULL = 9;
    localparam int IRQ_WRC = 10;
    localparam int GO_BIT = 0;

    // sizes
    localparam int ADDR_W = 18;
    localparam int WORD_W = 16;
    localparam int DMA_MAX = 8;
    localparam int BLK_WORDS = 4;

    // values after reset
    localparam logic [17:0] RST_ADDR = 18'h00000;
    localparam logic [7:0] RST_LEN = 8'h00;
    localparam logic [15:0] RST_IRQ = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WR = 2'b01,
        ST_RD = 2'b10
    } hdp_state_e;
endpackage

/* verilog/hdp_top.sv */
// host dma engine and frame buffer port
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module hdp_top #(
    parameter int MAX_WORDS = hdp_pkg::DMA_MAX,
    parameter int BLK = hdp_pkg::BLK_WORDS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_byte_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [17:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic [15:0] mem_rdata_i,
    input wire logic rx_frame_i,
    input wire logic rx_valid_i,
    input wire logic [15:0] rx_data_i,
    input wire logic rx_last_i,
    output logic rx_ready_o,
    output logic tx_valid_o,
    output logic [15:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic tx_space_i,
    output logic tx_frame_ok_o,
    output logic tx_frame_drop_o
);
    localparam int DW = $clog2(MAX_WORDS);
    localparam int CW = DW + 1;
    localparam int BW = $clog2(BLK);
    localparam int BCW = BW + 1;

    if (MAX_WORDS < 2 || MAX_WORDS > 128 || (1 << DW) != MAX_WORDS
        || BLK < 2 || (1 << BW) != BLK) begin : g_chk
        $error("hdp_top: depths must be powers of two in range");
    end

    ////////////////////////////////////////////////////////////////////
    // register port decode

    logic [17:0] addr_reg;
    logic [7:0] len_reg;
    logic [15:0] irq_reg;
    hdp_pkg::hdp_state_e st_reg;

    wire [6:0] wa = reg_addr_i[7:1];
    wire hit_irq = wa == hdp_pkg::OFS_IRQ[7:1];
    wire hit_fb = wa == hdp_pkg::OFS_FB[7:1];
    wire hit_eof = wa == hdp_pkg::OFS_EOF[7:1];
    wire hit_blk = wa == hdp_pkg::OFS_BLK[7:1];
    wire hit_rdy = wa == hdp_pkg::OFS_RDY[7:1];
    wire hit_alo = wa == hdp_pkg::OFS_ALO[7:1];
    wire hit_ahi = wa == hdp_pkg::OFS_AHI[7:1];
    wire hit_len = wa == hdp_pkg::OFS_LEN[7:1];
    wire hit_drd = wa == hdp_pkg::OFS_DRD[7:1];
    wire hit_dwr = wa == hdp_pkg::OFS_DWR[7:1];
    wire hit_dq = wa == hdp_pkg::OFS_DQ[7:1];

    // byte mode: odd address is the high lane, data on low bits
    wire [1:0] lane = reg_byte_i ? (reg_addr_i[0] ? 2'b10 : 2'b01) : 2'b11;
    wire [15:0] wd = reg_byte_i ? {2{reg_wdata_i[7:0]}} : reg_wdata_i;
    wire [15:0] wmask = {{8{lane[1]}}, {8{lane[0]}}};
    wire go_bit = lane[0] & wd[hdp_pkg::GO_BIT];
    wire dma_idle = st_reg == hdp_pkg::ST_IDLE;

    ////////////////////////////////////////////////////////////////////
    // dma data fifo

    logic [15:0] dq_mem [MAX_WORDS];
    logic [DW-1:0] dq_wp_reg;
    logic [DW-1:0] dq_rp_reg;
    logic [CW-1:0] dq_cnt_reg;
    logic [CW-1:0] rem_reg;
    logic [17:0] ptr_reg;
    logic dwph_reg;
    logic [7:0] dwlo_reg;
    logic drph_reg;

    wire go_rd = reg_wr_i & hit_drd & go_bit & dma_idle;
    wire go_wr = reg_wr_i & hit_dwr & go_bit & dma_idle;
    wire dq_full = dq_cnt_reg == CW'(MAX_WORDS);
    wire dq_empty = dq_cnt_reg == '0;
    wire dq_hwr = reg_wr_i & hit_dq & dma_idle;
    wire dq_hword = dq_hwr & (~reg_byte_i | dwph_reg) & ~dq_full;
    wire [15:0] dq_hdata = reg_byte_i ? {reg_wdata_i[7:0], dwlo_reg} : reg_wdata_i;
    // a lone low byte is pushed at write-start; its upper half is filler
    wire dq_flush = go_wr & dwph_reg & ~dq_full;
    wire dq_hrd = reg_rd_i & hit_dq & dma_idle & ~dq_empty;
    wire dq_hpop = dq_hrd & (~reg_byte_i | drph_reg);
    wire mem_fin = mem_req_o & mem_ack_i;
    wire issue = ~dma_idle & ~mem_req_o & (rem_reg != '0);
    wire dma_end = ~dma_idle & ~mem_req_o & (rem_reg == '0);
    wire dq_mpush = mem_fin & ~mem_we_o;
    wire dq_mpop = issue & (st_reg == hdp_pkg::ST_WR) & ~dq_empty;
    wire dq_push = dq_hword | dq_flush | dq_mpush;
    wire dq_pop = dq_hpop | dq_mpop;
    wire [15:0] dq_pdata = dq_mpush ? mem_rdata_i
                         : dq_flush ? {8'h00, dwlo_reg} : dq_hdata;
    wire [CW-1:0] len_eff = (len_reg > 8'(MAX_WORDS)) ? CW'(MAX_WORDS)
                          : CW'(len_reg);

    always_ff @(posedge clk_i) begin
        if (dq_push) begin
            dq_mem[dq_wp_reg] <= dq_pdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dq_wp_reg <= '0;
            dq_rp_reg <= '0;
            dq_cnt_reg <= '0;
        end else if (go_rd) begin
            // stale words would be read ahead of the fetched ones
            dq_wp_reg <= '0;
            dq_rp_reg <= '0;
            dq_cnt_reg <= '0;
        end else begin
            dq_wp_reg <= dq_wp_reg + DW'(dq_push);
            dq_rp_reg <= dq_rp_reg + DW'(dq_pop);
            dq_cnt_reg <= dq_cnt_reg + CW'(dq_push) - CW'(dq_pop);
        end
    end

    // byte phase of the data fifo, low byte first each way
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dwph_reg <= 1'b0;
            dwlo_reg <= 8'h00;
            drph_reg <= 1'b0;
        end else begin
            if (go_wr | go_rd) begin
                dwph_reg <= 1'b0;
            end else if (dq_hwr & reg_byte_i) begin
                dwph_reg <= ~dwph_reg;
                dwlo_reg <= reg_wdata_i[7:0];
            end
            if (go_rd) begin
                drph_reg <= 1'b0;
            end else if (dq_hrd & reg_byte_i) begin
                drph_reg <= ~drph_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // dma sequencer

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= hdp_pkg::ST_IDLE;
            rem_reg <= '0;
            ptr_reg <= hdp_pkg::RST_ADDR;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= hdp_pkg::RST_ADDR;
            mem_wdata_o <= 16'h0000;
        end else begin
            unique case (st_reg)
                hdp_pkg::ST_IDLE: begin
                    rem_reg <= len_eff;
                    ptr_reg <= addr_reg;
                    if (go_wr) begin
                        st_reg <= hdp_pkg::ST_WR;
                    end else if (go_rd) begin
                        st_reg <= hdp_pkg::ST_RD;
                    end
                end
                hdp_pkg::ST_WR, hdp_pkg::ST_RD: begin
                    if (issue) begin
                        mem_req_o <= 1'b1;
                        mem_we_o <= st_reg == hdp_pkg::ST_WR;
                        mem_addr_o <= ptr_reg;
                        mem_wdata_o <= dq_mem[dq_rp_reg];
                    end
                    if (mem_fin) begin
                        mem_req_o <= 1'b0;
                        ptr_reg <= ptr_reg + 18'h00001;
                        rem_reg <= rem_reg - CW'(1);
                    end
                    if (dma_end) begin
                        st_reg <= hdp_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_reg <= hdp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receive block, host reads through the frame fifo register

    logic [15:0] rxb_mem [BLK];
    logic [BCW-1:0] rx_cnt_reg;
    logic [BW-1:0] rx_rp_reg;
    logic rx_rdy_reg;
    logic frph_reg;

    wire rx_store = rx_valid_i & rx_ready_o;
    // block is ready when full or when the frame's last word lands
    wire rx_set = rx_store & ((rx_cnt_reg == BCW'(BLK - 1)) | rx_last_i);
    wire fb_hrd = reg_rd_i & hit_fb & rx_rdy_reg;
    wire fb_pop = fb_hrd & (~reg_byte_i | frph_reg);
    wire rx_done = fb_pop & ({1'b0, rx_rp_reg} + BCW'(1) == rx_cnt_reg);

    always_ff @(posedge clk_i) begin
        if (rx_store) begin
            rxb_mem[rx_cnt_reg[BW-1:0]] <= rx_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_cnt_reg <= '0;
            rx_rp_reg <= '0;
            rx_rdy_reg <= 1'b0;
            rx_ready_o <= 1'b0;
            frph_reg <= 1'b0;
        end else begin
            rx_ready_o <= rx_done | (~rx_rdy_reg & ~rx_set);
            if (fb_hrd & reg_byte_i) begin
                frph_reg <= ~frph_reg;
            end
            if (rx_done) begin
                rx_cnt_reg <= '0;
                rx_rp_reg <= '0;
                rx_rdy_reg <= 1'b0;
            end else begin
                rx_cnt_reg <= rx_cnt_reg + BCW'(rx_store);
                rx_rp_reg <= rx_rp_reg + BW'(fb_pop);
                if (rx_set) begin
                    rx_rdy_reg <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit block, drained through the two-entry buffer

    logic [15:0] txb_mem [BLK];
    logic [BCW-1:0] tx_cnt_reg;
    logic [BCW-1:0] txi_reg;
    logic tx_busy_reg;
    logic tx_eof_reg;
    logic fwph_reg;
    logic [7:0] fwlo_reg;
    logic sk_ready;

    wire fb_hwr = reg_wr_i & hit_fb & ~tx_busy_reg & (tx_cnt_reg != BCW'(BLK));
    wire fb_word = fb_hwr & (~reg_byte_i | fwph_reg);
    wire [15:0] fb_wdata = reg_byte_i ? {reg_wdata_i[7:0], fwlo_reg} : reg_wdata_i;
    wire go_blk = reg_wr_i & hit_blk & go_bit & ~tx_busy_reg;
    wire go_eof = reg_wr_i & hit_eof & go_bit & ~tx_busy_reg;
    wire sk_valid = tx_busy_reg & (txi_reg != tx_cnt_reg);
    wire sk_push = sk_valid & sk_ready;
    wire tx_fin = tx_busy_reg & (txi_reg == tx_cnt_reg);
    // space is sampled once, so one end commit gets exactly one answer
    wire wr_cmpl = tx_fin & (~tx_eof_reg | tx_space_i);
    wire buf_full = tx_fin & tx_eof_reg & ~tx_space_i;

    always_ff @(posedge clk_i) begin
        if (fb_word) begin
            txb_mem[tx_cnt_reg[BW-1:0]] <= fb_wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_cnt_reg <= '0;
            txi_reg <= '0;
            tx_busy_reg <= 1'b0;
            tx_eof_reg <= 1'b0;
            fwph_reg <= 1'b0;
            fwlo_reg <= 8'h00;
            tx_frame_ok_o <= 1'b0;
            tx_frame_drop_o <= 1'b0;
        end else begin
            tx_frame_ok_o <= wr_cmpl & tx_eof_reg;
            tx_frame_drop_o <= buf_full;
            if (fb_hwr & reg_byte_i) begin
                fwph_reg <= ~fwph_reg;
                fwlo_reg <= reg_wdata_i[7:0];
            end
            if (tx_fin) begin
                tx_busy_reg <= 1'b0;
                tx_cnt_reg <= '0;
                txi_reg <= '0;
            end else begin
                tx_cnt_reg <= tx_cnt_reg + BCW'(fb_word);
                txi_reg <= txi_reg + BCW'(sk_push);
                if (go_blk | go_eof) begin
                    tx_busy_reg <= 1'b1;
                    tx_eof_reg <= go_eof;
                    fwph_reg <= 1'b0;
                end
            end
        end
    end

    hdp_buf2 #(
        .WIDTH(16)
    ) u_txbuf (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(sk_valid),
        .in_data_i(txb_mem[txi_reg[BW-1:0]]),
        .in_ready_o(sk_ready),
        .out_valid_o(tx_valid_o),
        .out_data_o(tx_data_o),
        .out_ready_i(tx_ready_i)
    );

    ////////////////////////////////////////////////////////////////////
    // configuration and interrupt flags

    wire [15:0] irq_set = (16'(dma_end) << hdp_pkg::IRQ_DMA)
                        | (16'(rx_frame_i) << hdp_pkg::IRQ_RXF)
                        | (16'(buf_full) << hdp_pkg::IRQ_FULL)
                        | (16'(wr_cmpl) << hdp_pkg::IRQ_WRC);
    wire [15:0] irq_clr = (reg_wr_i & hit_irq) ? (wd & wmask) : 16'h0000;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_reg <= hdp_pkg::RST_IRQ;
            addr_reg <= hdp_pkg::RST_ADDR;
            len_reg <= hdp_pkg::RST_LEN;
        end else begin
            // write one clears; a set in the same cycle wins
            irq_reg <= (irq_reg & ~irq_clr) | irq_set;
            if (reg_wr_i & hit_alo) begin
                addr_reg[15:0] <= (addr_reg[15:0] & ~wmask) | (wd & wmask);
            end
            if (reg_wr_i & hit_ahi & lane[0]) begin
                addr_reg[17:16] <= wd[1:0];
            end
            if (reg_wr_i & hit_len & lane[0]) begin
                len_reg <= wd[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data

    wire [15:0] rword = hit_irq ? irq_reg
                      : hit_fb ? (rx_rdy_reg ? rxb_mem[rx_rp_reg] : 16'h0000)
                      : hit_rdy ? {15'h0000, rx_rdy_reg}
                      : hit_alo ? addr_reg[15:0]
                      : hit_ahi ? {14'h0000, addr_reg[17:16]}
                      : hit_len ? {8'h00, len_reg}
                      : (hit_dq & ~dq_empty) ? dq_mem[dq_rp_reg]
                      : 16'h0000;
    wire sel_hi = hit_fb ? frph_reg : hit_dq ? drph_reg : reg_addr_i[0];
    wire [7:0] rbyte = sel_hi ? rword[15:8] : rword[7:0];
    wire [15:0] rnext = reg_byte_i ? {8'h00, rbyte} : rword;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 16'h0000;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rnext;
            end
        end
    end
endmodule
